// [rtl/prs_pkg.sv]
// prs_pkg: constants, types and APB carriers for the prbs lfsr generator.
// assumes a single 100 MHz clock domain and an APB master with 32-bit data.
package prs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // generator configuration, fixed at build time
    localparam logic [31:0] PRS_POLY_HI      = 32'h0000_0000;
    localparam logic [31:0] PRS_POLY_LO      = 32'h0000_0060;
    localparam logic [63:0] PRS_POLY         = {PRS_POLY_HI, PRS_POLY_LO};        // RULE_07
    localparam logic [31:0] PRS_RSEED_HI     = 32'h0000_0000;
    localparam logic [31:0] PRS_RSEED_LO     = 32'h0000_0001;
    localparam logic [63:0] PRS_RESET_SEED   = {PRS_RSEED_HI, PRS_RSEED_LO};    // RULE_08
    localparam int          PRS_W            = $clog2(PRS_POLY);                 // RULE_01
    localparam int          PRS_NBITS        = 8;
    localparam logic        PRS_TYPE_GALOIS  = 1'b0;
    localparam logic        PRS_TYPE_FIBO    = 1'b1;
    localparam logic        PRS_TYPE         = PRS_TYPE_GALOIS;
    localparam logic        PRS_XNOR         = 1'b0;
    localparam logic [PRS_W-1:0] PRS_TAPS    = PRS_POLY[PRS_W-1:0];
    localparam logic [PRS_W-1:0] PRS_SEED_RV = PRS_RESET_SEED[PRS_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses
    localparam int          PRS_AW           = 8;
    localparam logic [7:0]  PRS_CTRL_ADDR    = 8'h00;
    localparam logic [7:0]  PRS_SEED_LO_ADDR = 8'h04;
    localparam logic [7:0]  PRS_SEED_HI_ADDR = 8'h08;
    localparam logic [7:0]  PRS_STAT_LO_ADDR = 8'h0c;
    localparam logic [7:0]  PRS_STAT_HI_ADDR = 8'h10;
    localparam logic [7:0]  PRS_BITS_ADDR    = 8'h14;
    localparam int          PRS_CTRL_EN_BIT  = 0;
    localparam int          PRS_CTRL_LD_BIT  = 1;
    localparam logic        PRS_EN_RV        = 1'b0;
    localparam logic [63:0] PRS_RTSEED_RV    = 64'h0000_0000_0000_0001;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [PRS_AW-1:0] paddr;
        logic [31:0]       pwdata;
    } prs_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } prs_apb_rsp_t;

    // feedback combine: xnor variant inverts every tap merge
    function automatic logic prs_combine(input logic a, input logic b);
        prs_combine = PRS_XNOR ? ~(a ^ b) : (a ^ b);
    endfunction : prs_combine

endpackage : prs_pkg

// [rtl/prs_lfsr_step.sv]
// prs_lfsr_step: combinational advance of the lfsr state by PRS_NBITS steps.
// assumes the caller registers state_out; bits_out[0] is the first new bit.
`timescale 1ns/100ps
module prs_lfsr_step
    import prs_pkg::*;
(
    input  wire logic [PRS_W-1:0]     state_in,
    output logic      [PRS_W-1:0]     state_out,
    output logic      [PRS_NBITS-1:0] bits_out
);

    logic [PRS_W-1:0] s;
    logic [PRS_W-1:0] n;
    logic             fb;

    always_comb
    begin
        s        = state_in;
        n        = '0;
        fb       = 1'b0;
        bits_out = '0;
        for (int i = 0; i < PRS_NBITS; i++)                    // RULE_05
        begin
            if (PRS_TYPE == PRS_TYPE_FIBO)                     // RULE_06
            begin
                fb = 1'b0;
                for (int k = 0; k < PRS_W; k++)
                begin
                    if (PRS_TAPS[k])
                    begin
                        fb = fb ^ s[k];
                    end
                end
                if (PRS_XNOR)                                  // RULE_09
                begin
                    fb = ~fb;
                end
                n = {s[PRS_W-2:0], fb};
            end
            else
            begin
                // galois: msb leaves and is folded into the tapped stages
                fb   = s[PRS_W-1];
                n[0] = fb;
                for (int j = 1; j < PRS_W; j++)
                begin
                    n[j] = PRS_TAPS[j-1] ? prs_combine(s[j-1], fb) : s[j-1]; // RULE_09
                end
            end
            bits_out[i] = fb;
            s           = n;
        end
        state_out = s;
    end

endmodule : prs_lfsr_step

// [rtl/prs_lfsr_top.sv]
// What this block does
// [RULE_01] state register width is clog2 of the polynomial value
// [RULE_02] active-low reset loads the reset seed, overriding all controls
// [RULE_03] seed-load strobe loads the runtime seed, overriding enable
// [RULE_04] enable advances state by configured iterations, else state holds
// [RULE_05] bits-per-cycle sets how many new bits each advance yields
// [RULE_06] structure select zero builds Galois, one builds Fibonacci
// [RULE_07] polynomial given as upper half 63:32 and lower half 31:0
// [RULE_08] reset seed given as upper and lower 32-bit halves
// [RULE_09] xnor option uses xnor feedback, otherwise xor
// [RULE_10] output shows bits from the latest advance, first bit in bit 0
//
// prs_lfsr_top: prbs generator with APB control and status registers.
// assumes an APB master on the same clock; pready comes in the first access cycle.
`timescale 1ns/100ps
module prs_lfsr_top
    import prs_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    input  wire prs_apb_req_t         apb_req,
    output prs_apb_rsp_t              apb_rsp,
    output logic      [PRS_NBITS-1:0] prbs_bits,
    output logic                      prbs_valid
);

    ////////////////////////////////////////////////////////////////////////////
    // apb decode

    function automatic logic prs_mapped(input logic [PRS_AW-1:0] a);
        prs_mapped = (a == PRS_CTRL_ADDR)    || (a == PRS_SEED_LO_ADDR) ||
                     (a == PRS_SEED_HI_ADDR) || (a == PRS_STAT_LO_ADDR) ||
                     (a == PRS_STAT_HI_ADDR) || (a == PRS_BITS_ADDR);
    endfunction : prs_mapped

    logic                 setup;
    logic                 access;
    logic                 wr;
    logic [63:0]          state_ext;
    logic                 enable_r;
    logic                 enable_nxt;
    logic                 load;
    logic [63:0]          rtseed_r;
    logic [63:0]          rtseed_nxt;
    logic [31:0]          prdata_r;
    logic [31:0]          prdata_nxt;
    logic [PRS_W-1:0]     state_r;                             // RULE_01
    logic [PRS_W-1:0]     state_nxt;
    logic [PRS_W-1:0]     step_state;
    logic [PRS_NBITS-1:0] step_bits;
    logic [PRS_NBITS-1:0] bits_r;
    logic [PRS_NBITS-1:0] bits_nxt;
    logic                 valid_r;
    logic                 valid_nxt;

    assign setup     = apb_req.psel & ~apb_req.penable;
    assign access    = apb_req.psel & apb_req.penable;
    assign wr        = access & apb_req.pwrite;
    assign state_ext = 64'(state_r);

    // zero wait state: read data is captured in setup and writes at the access edge, so pready can rise at once
    assign apb_rsp.pready  = access;
    assign apb_rsp.pslverr = access & ~prs_mapped(apb_req.paddr);
    assign apb_rsp.prdata  = prdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_comb
    begin
        enable_nxt = enable_r;
        rtseed_nxt = rtseed_r;
        prdata_nxt = prdata_r;
        load       = 1'b0;
        if (wr)
        begin
            case (apb_req.paddr)
                PRS_CTRL_ADDR:
                begin
                    enable_nxt = apb_req.pwdata[PRS_CTRL_EN_BIT];
                    load       = apb_req.pwdata[PRS_CTRL_LD_BIT];
                end
                PRS_SEED_LO_ADDR: rtseed_nxt[31:0]  = apb_req.pwdata;
                PRS_SEED_HI_ADDR: rtseed_nxt[63:32] = apb_req.pwdata;
                default:          rtseed_nxt        = rtseed_r;
            endcase
        end
        if (setup)
        begin
            case (apb_req.paddr)
                PRS_CTRL_ADDR:    prdata_nxt = {31'h0000_0000, enable_r};
                PRS_SEED_LO_ADDR: prdata_nxt = rtseed_r[31:0];
                PRS_SEED_HI_ADDR: prdata_nxt = rtseed_r[63:32];
                PRS_STAT_LO_ADDR: prdata_nxt = state_ext[31:0];
                PRS_STAT_HI_ADDR: prdata_nxt = state_ext[63:32];
                PRS_BITS_ADDR:    prdata_nxt = 32'(bits_r);
                default:          prdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            enable_r <= PRS_EN_RV;
            rtseed_r <= PRS_RTSEED_RV;
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            enable_r <= enable_nxt;
            rtseed_r <= rtseed_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // generator

    prs_lfsr_step u_step
    (
        .state_in  (state_r),
        .state_out (step_state),
        .bits_out  (step_bits)
    );

    always_comb
    begin
        state_nxt = state_r;                                   // RULE_04
        bits_nxt  = bits_r;
        valid_nxt = 1'b0;
        if (load)
        begin
            state_nxt = rtseed_r[PRS_W-1:0];                   // RULE_03
        end
        else if (enable_r)
        begin
            state_nxt = step_state;                            // RULE_04
            bits_nxt  = step_bits;                             // RULE_10
            valid_nxt = 1'b1;
        end
    end

    // the reset seed is a build constant, so the async reset stays a constant load
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= PRS_SEED_RV;                            // RULE_02 RULE_08
            bits_r  <= '0;
            valid_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            bits_r  <= bits_nxt;
            valid_r <= valid_nxt;
        end
    end

    assign prbs_bits  = bits_r;                                // RULE_10
    assign prbs_valid = valid_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_width;
        $bits(state_r) == $clog2({PRS_POLY_HI, PRS_POLY_LO});
    endproperty
    a_width: assert property (p_width) else $error("state width mismatch"); // RULE_01 RULE_07

    property p_reset_seed;
        $rose(rst_b) |-> state_r == PRS_SEED_RV;
    endproperty
    a_reset_seed: assert property (p_reset_seed) else $error("reset seed not loaded"); // RULE_02

    property p_load;
        (wr && apb_req.paddr == PRS_CTRL_ADDR && apb_req.pwdata[PRS_CTRL_LD_BIT])
            |=> state_r == $past(rtseed_r[PRS_W-1:0]);
    endproperty
    a_load: assert property (p_load) else $error("seed load missed"); // RULE_03

    property p_advance;
        (!load && enable_r) |=> state_r == $past(step_state) && prbs_valid;
    endproperty
    a_advance: assert property (p_advance) else $error("state did not advance"); // RULE_04

    property p_hold;
        (!load && !enable_r) |=> $stable(state_r) && !prbs_valid;
    endproperty
    a_hold: assert property (p_hold) else $error("state moved while idle"); // RULE_04

    property p_bits;
        prbs_valid |-> prbs_bits == $past(step_bits) && state_r == $past(step_state);
    endproperty
    a_bits: assert property (p_bits) else $error("output bits not from last advance"); // RULE_05 RULE_10

    property p_bits_hold;
        !prbs_valid ##1 !prbs_valid |-> $stable(prbs_bits);
    endproperty
    a_bits_hold: assert property (p_bits_hold) else $error("output bits changed without advance"); // RULE_10

    property p_enable_wr;
        (wr && apb_req.paddr == PRS_CTRL_ADDR) ##1 !load [*2]
            |-> enable_r == $past(apb_req.pwdata[PRS_CTRL_EN_BIT], 2);
    endproperty
    a_enable_wr: assert property (p_enable_wr) else $error("enable write lost"); // RULE_04

    property p_ready;
        setup |=> apb_rsp.pready || !apb_req.psel;
    endproperty
    a_ready: assert property (p_ready) else $error("pready late");

endmodule : prs_lfsr_top

// [tb/prs_sink_model.sv]
// prs_sink_model: downstream logic that consumes the generated bits.
// assumes prbs_valid marks one fresh word per cycle on the shared clock.
`timescale 1ns/100ps
module prs_sink_model
    import prs_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst_b,
    input  wire logic [PRS_NBITS-1:0] prbs_bits,
    input  wire logic                 prbs_valid,
    output logic      [31:0]          bit_cnt_r,
    output logic      [PRS_NBITS-1:0] last_bits_r
);
    // counts bits taken and keeps the last word; a stuck valid shows up as a count mismatch
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bit_cnt_r   <= 32'h0000_0000;
            last_bits_r <= '0;
        end
        else if (prbs_valid)
        begin
            bit_cnt_r   <= bit_cnt_r + 32'(PRS_NBITS);
            last_bits_r <= prbs_bits;
        end
    end
endmodule : prs_sink_model

// [tb/tb_top.sv]
// tb_top: self-checking bench for the prbs generator and its APB registers.
// assumes the zero-wait slave and the generator build fixed in prs_pkg.
`timescale 1ns/100ps
module tb_top
    import prs_pkg::*;
();
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        err;
    } prs_row_t;

    localparam logic [31:0] SEED_V = 32'h0000_005a;

    logic                 clock;
    logic                 rst_b;
    prs_apb_req_t         req;
    prs_apb_rsp_t         rsp;
    logic [PRS_NBITS-1:0] prbs_bits;
    logic                 prbs_valid;
    logic [31:0]          bit_cnt;
    logic [PRS_NBITS-1:0] sink_bits;
    logic [PRS_W-1:0]     exp_st;
    logic [PRS_NBITS-1:0] exp_bits;
    logic [31:0]          rd;
    logic                 er;
    int                   failures;
    int                   total_checks;
    int                   n_adv;
    prs_row_t             rows [14];

    prs_lfsr_top dut (.clock(clock), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
                      .prbs_bits(prbs_bits), .prbs_valid(prbs_valid));
    prs_sink_model sink (.clock(clock), .rst_b(rst_b), .prbs_bits(prbs_bits),
                         .prbs_valid(prbs_valid), .bit_cnt_r(bit_cnt), .last_bits_r(sink_bits));

    ////////////////////////////////////////////////////////////////////////////
    // reference generator; fibonacci xnor matches the rtl step for any number of taps
    function automatic logic [PRS_W+PRS_NBITS-1:0] lfsr_adv(input logic [PRS_W-1:0] s);
        logic [PRS_NBITS-1:0] b;
        logic                 fb;
        for (int i = 0; i < PRS_NBITS; i++)
        begin
            fb   = (PRS_TYPE == PRS_TYPE_FIBO) ? (^(s & PRS_TAPS) ^ PRS_XNOR) : s[PRS_W-1];
            b[i] = fb;
            for (int j = PRS_W-1; j > 0; j--)
                s[j] = (PRS_TYPE == PRS_TYPE_GALOIS && PRS_TAPS[j-1]) ? (s[j-1] ^ fb ^ PRS_XNOR) : s[j-1];
            s[0] = fb;
        end
        return {s, b};
    endfunction : lfsr_adv

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one transfer; starts at the next edge so back-to-back calls never collide
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= a;
        req.pwdata  <= d;
        @(posedge clock);
        req.penable <= 1'b1;
        @(posedge clock);
        // no wait count assumed: only the watchdog ends a hung transfer
        while (rsp.pready !== 1'b1)
        begin
            @(posedge clock);
        end
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial
    begin
        #200000;
        failures++;
        report_and_stop();
    end

    // every advance is compared against the reference
    always @(negedge clock)
        if (rst_b === 1'b1 && prbs_valid === 1'b1)
        begin
            {exp_st, exp_bits} = lfsr_adv(exp_st);
            n_adv++;
            check(32'(prbs_bits), 32'(exp_bits));
        end

    initial
    begin
        failures = 0;
        total_checks = 0;
        n_adv = 0;
        req = '0;
        rst_b = 1'b0;
        exp_st = PRS_SEED_RV;
        exp_bits = '0;
        rows = '{'{1'b0, PRS_CTRL_ADDR, 32'h0, 32'h0, 1'b0},
                 '{1'b0, PRS_SEED_LO_ADDR, 32'h0, PRS_RTSEED_RV[31:0], 1'b0},
                 '{1'b0, PRS_SEED_HI_ADDR, 32'h0, PRS_RTSEED_RV[63:32], 1'b0},
                 '{1'b0, PRS_STAT_LO_ADDR, 32'h0, 32'(PRS_SEED_RV), 1'b0},
                 '{1'b0, PRS_STAT_HI_ADDR, 32'h0, 32'h0, 1'b0},
                 '{1'b0, PRS_BITS_ADDR, 32'h0, 32'h0, 1'b0},
                 '{1'b1, PRS_SEED_LO_ADDR, SEED_V, 32'h0, 1'b0},
                 '{1'b1, PRS_SEED_HI_ADDR, 32'h1234_abcd, 32'h0, 1'b0},
                 '{1'b1, PRS_STAT_LO_ADDR, 32'h0000_00ff, 32'h0, 1'b0},
                 '{1'b0, PRS_SEED_LO_ADDR, 32'h0, SEED_V, 1'b0},
                 '{1'b0, PRS_SEED_HI_ADDR, 32'h0, 32'h1234_abcd, 1'b0},
                 '{1'b0, PRS_STAT_LO_ADDR, 32'h0, 32'(PRS_SEED_RV), 1'b0},
                 '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1},
                 '{1'b1, 8'h1c, 32'h5, 32'h0, 1'b1}};
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].addr, rows[i].wdata);
            check(32'(er), 32'(rows[i].err));
            if (!rows[i].wr)
                check(rd, rows[i].rdata);
        end
        $display("register table done");
        apb(1'b1, PRS_CTRL_ADDR, 32'h2);
        exp_st = SEED_V[PRS_W-1:0];
        #1;
        check(32'(prbs_valid), 32'h0);
        apb(1'b0, PRS_STAT_LO_ADDR, 32'h0);
        check(rd, 32'(exp_st));
        $display("seed load done");
        apb(1'b1, PRS_CTRL_ADDR, 32'h1);
        repeat (10) @(posedge clock);
        // load together with enable: the load must win
        apb(1'b1, PRS_CTRL_ADDR, 32'h3);
        exp_st = SEED_V[PRS_W-1:0];
        #1;
        check(32'(prbs_valid), 32'h0);
        repeat (5) @(posedge clock);
        apb(1'b1, PRS_CTRL_ADDR, 32'h0);
        repeat (2) @(posedge clock);
        #1;
        check(32'(prbs_valid), 32'h0);
        apb(1'b0, PRS_STAT_LO_ADDR, 32'h0);
        check(rd, 32'(exp_st));
        apb(1'b0, PRS_BITS_ADDR, 32'h0);
        check(rd, 32'(exp_bits));
        check(32'(n_adv), 32'd20);
        check(bit_cnt, 32'(n_adv * PRS_NBITS));
        check(32'(sink_bits), 32'(exp_bits));
        $display("advance run done");
        apb(1'b1, PRS_CTRL_ADDR, 32'h1);
        repeat (3) @(posedge clock);
        rst_b <= 1'b0;
        #1;
        check(32'(prbs_valid), 32'h0);
        check(32'(prbs_bits), 32'h0);
        exp_st = PRS_SEED_RV;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        apb(1'b0, PRS_STAT_LO_ADDR, 32'h0);
        check(rd, 32'(exp_st));
        apb(1'b0, PRS_CTRL_ADDR, 32'h0);
        check(rd, 32'h0);
        $display("mid-run reset done");
        report_and_stop();
    end
endmodule : tb_top
